// >>> cfg_key_pkg.sv
`default_nettype none
package cfg_key_pkg;
  localparam int KEY_LEN = 32;
  localparam logic [7:0] VKEY_FIRST = 8'h96;
  localparam logic [7:0] VKEY_LAST = 8'h1A;
  localparam logic [7:0] CMD_CSN = 8'h06;
  localparam logic [7:0] CMD_LDEV = 8'h15;
  localparam logic [7:0] CMD_IO0 = 8'h47;
  localparam logic [7:0] CMD_IO1 = 8'h48;
  localparam logic [7:0] CMD_IO2 = 8'h42;
  localparam logic [7:0] CMD_IRQ0 = 8'h22;
  localparam logic [7:0] CMD_IRQ1 = 8'h27;
  localparam logic [7:0] CMD_DMA0 = 8'h2A;
  localparam logic [7:0] CMD_DMA1 = 8'h25;
  localparam logic [7:0] CMD_ACT = 8'h33;
  localparam logic [7:0] CMD_CHIP_ON = 8'h79;
  localparam logic [7:0] ACT_ON = 8'h01;
  localparam logic [7:0] ACT_OFF = 8'h00;
  localparam logic [7:0] DIS_STD_KEY = 8'h55;
  localparam logic [7:0] DIS_VEND_KEY = 8'h56;
  localparam logic [2:0] KEY_DIS_OFFSET = 3'h5;
  localparam int NUM_LDEV = 6;
  localparam logic [2:0] LDEV_MAX = 3'h5;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_BASE = 16'h0000;
  typedef enum logic [3:0] {
    F_NONE, F_CSN, F_LDEV, F_IO0, F_IO1, F_IO2, F_IRQ0, F_IRQ1, F_DMA0, F_DMA1, F_ACT
  } field_t;
endpackage
`default_nettype wire

// >>> config_key_and_direct_program.sv
`default_nettype none
// Summary of operation
// - full vendor key enters configuration mode
// - key matched against 32 ordered bytes
// - key recognition needs no serial identifier
// - csn command stores one value byte
// - command 15h selects logical device 0-5
// - io base commands take high then low
// - irq select commands take one byte
// - dma select commands take one byte
// - command 33h activates or deactivates device
// - byte 79h activates the whole chip
// - 55h at control offset 5 disables standard key
// - 56h at control offset 5 disables vendor key
// - disabled keys stay off until bus reset
// - active devices keep resources after disabling
// - serial memory may disable both keys
// - config mode allows hostload or direct programming
// - inactive after reset, watch every address write
module config_key_and_direct_program
  import cfg_key_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic addr_wr_in,
  input wire logic [7:0] addr_data_in,
  input wire logic ctrl_wr_in,
  input wire logic [2:0] ctrl_offset_in,
  input wire logic [7:0] ctrl_data_in,
  input wire logic eeprom_std_key_dis_in,
  input wire logic eeprom_vend_key_dis_in,
  input wire logic hostload_done_in,
  output logic config_mode_out,
  output logic chip_active_out,
  output logic std_key_disabled_out,
  output logic vend_key_disabled_out,
  output logic hostload_enable_out,
  output logic [7:0] csn_out,
  output logic [2:0] ldev_sel_out,
  output logic [NUM_LDEV-1:0] ldev_active_out,
  output logic [NUM_LDEV*16-1:0] io_base0_out,
  output logic [NUM_LDEV*16-1:0] io_base1_out,
  output logic [NUM_LDEV*16-1:0] io_base2_out,
  output logic [NUM_LDEV*8-1:0] irq_sel0_out,
  output logic [NUM_LDEV*8-1:0] irq_sel1_out,
  output logic [NUM_LDEV*8-1:0] dma_sel0_out,
  output logic [NUM_LDEV*8-1:0] dma_sel1_out
);

  // ----------------------------------------
  // key table
  // ----------------------------------------
  function automatic logic [7:0] key_byte(input logic [4:0] idx);
    logic [7:0] k;
    k = 8'h00;
    case (idx)
      5'h00: k = VKEY_FIRST; 5'h01: k = 8'h35; 5'h02: k = 8'h9A; 5'h03: k = 8'hCD;
      5'h04: k = 8'hE6; 5'h05: k = 8'hF3; 5'h06: k = 8'h79; 5'h07: k = 8'hBC;
      5'h08: k = 8'h5E; 5'h09: k = 8'hAF; 5'h0A: k = 8'h57; 5'h0B: k = 8'h2B;
      5'h0C: k = 8'h15; 5'h0D: k = 8'h8A; 5'h0E: k = 8'hC5; 5'h0F: k = 8'hE2;
      5'h10: k = 8'hF1; 5'h11: k = 8'hF8; 5'h12: k = 8'h7C; 5'h13: k = 8'h3E;
      5'h14: k = 8'h9F; 5'h15: k = 8'h4F; 5'h16: k = 8'h27; 5'h17: k = 8'h13;
      5'h18: k = 8'h09; 5'h19: k = 8'h84; 5'h1A: k = 8'h42; 5'h1B: k = 8'hA1;
      5'h1C: k = 8'hD0; 5'h1D: k = 8'h68; 5'h1E: k = 8'h34; 5'h1F: k = VKEY_LAST;
      default: k = 8'h00;
    endcase
    return k;
  endfunction

  function automatic field_t cmd_field(input logic [7:0] c);
    field_t f;
    f = F_NONE;
    case (c)
      CMD_CSN: f = F_CSN;
      CMD_LDEV: f = F_LDEV;
      CMD_IO0: f = F_IO0;
      CMD_IO1: f = F_IO1;
      CMD_IO2: f = F_IO2;
      CMD_IRQ0: f = F_IRQ0;
      CMD_IRQ1: f = F_IRQ1;
      CMD_DMA0: f = F_DMA0;
      CMD_DMA1: f = F_DMA1;
      CMD_ACT: f = F_ACT;
      default: f = F_NONE;
    endcase
    return f;
  endfunction

  // ----------------------------------------
  // key detection
  // ----------------------------------------
  logic [4:0] key_idx;
  logic key_hit;
  logic key_done;
  logic vend_key_off;
  assign vend_key_off = vend_key_disabled_out | eeprom_vend_key_dis_in;
  // no serial qualifier: every part reacts alike
  assign key_hit = addr_data_in == key_byte(key_idx);
  assign key_done = addr_wr_in && key_hit && key_idx == 5'(KEY_LEN - 1) && !vend_key_off;

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      key_idx <= 5'h00;
    end else if (addr_wr_in) begin
      if (key_hit && !vend_key_off) begin
        key_idx <= key_idx + 5'h01;
      end else if (addr_data_in == VKEY_FIRST && !vend_key_off) begin
        key_idx <= 5'h01;
      end else begin
        key_idx <= 5'h00;
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      config_mode_out <= 1'b0;
    end else if (key_done) begin
      config_mode_out <= 1'b1;
    end
  end

  // hostload allowed from key entry until hostload_done_in, config mode stays set
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      hostload_enable_out <= 1'b0;
    end else if (key_done) begin
      hostload_enable_out <= 1'b1;
    end else if (hostload_done_in) begin
      hostload_enable_out <= 1'b0;
    end
  end

  // ----------------------------------------
  // key disables
  // ----------------------------------------
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      std_key_disabled_out <= 1'b0;
      vend_key_disabled_out <= 1'b0;
    end else begin
      if ((ctrl_wr_in && ctrl_offset_in == KEY_DIS_OFFSET && ctrl_data_in == DIS_STD_KEY)
          || eeprom_std_key_dis_in) begin
        std_key_disabled_out <= 1'b1;
      end
      if ((ctrl_wr_in && ctrl_offset_in == KEY_DIS_OFFSET && ctrl_data_in == DIS_VEND_KEY)
          || eeprom_vend_key_dis_in) begin
        vend_key_disabled_out <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // command parser
  // ----------------------------------------
  field_t pend_field;
  logic [1:0] args_left;
  logic [7:0] hi_byte;
  logic cmd_wr;
  logic arg_wr;
  logic [2:0] sel;
  assign cmd_wr = addr_wr_in && config_mode_out && args_left == 2'd0 && !key_done;
  assign arg_wr = addr_wr_in && config_mode_out && args_left != 2'd0;
  assign sel = ldev_sel_out;

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pend_field <= F_NONE;
      args_left <= 2'd0;
      hi_byte <= RESET_BYTE;
    end else if (cmd_wr) begin
      pend_field <= cmd_field(addr_data_in);
      case (cmd_field(addr_data_in))
        F_IO0, F_IO1, F_IO2: args_left <= 2'd2;
        F_NONE: args_left <= 2'd0;
        default: args_left <= 2'd1;
      endcase
    end else if (arg_wr) begin
      args_left <= args_left - 2'd1;
      if (args_left == 2'd2) begin
        hi_byte <= addr_data_in;
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      chip_active_out <= 1'b0;
    end else if (cmd_wr && addr_data_in == CMD_CHIP_ON) begin
      chip_active_out <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      csn_out <= RESET_BYTE;
      ldev_sel_out <= 3'h0;
    end else if (arg_wr && pend_field == F_CSN) begin
      csn_out <= addr_data_in;
    end else if (arg_wr && pend_field == F_LDEV && addr_data_in <= {5'h00, LDEV_MAX}) begin
      ldev_sel_out <= addr_data_in[2:0];
    end
  end

  // ----------------------------------------
  // per device resources
  // ----------------------------------------
  // resources stay live regardless of key disables
  genvar g;
  generate
    for (g = 0; g < NUM_LDEV; g++) begin : g_ldev
      always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
          io_base0_out[g*16 +: 16] <= RESET_BASE;
          io_base1_out[g*16 +: 16] <= RESET_BASE;
          io_base2_out[g*16 +: 16] <= RESET_BASE;
          irq_sel0_out[g*8 +: 8] <= RESET_BYTE;
          irq_sel1_out[g*8 +: 8] <= RESET_BYTE;
          dma_sel0_out[g*8 +: 8] <= RESET_BYTE;
          dma_sel1_out[g*8 +: 8] <= RESET_BYTE;
          ldev_active_out[g] <= 1'b0;
        end else if (arg_wr && sel == 3'(g)) begin
          case (pend_field)
            F_IO0: if (args_left == 2'd1) io_base0_out[g*16 +: 16] <= {hi_byte, addr_data_in};
            F_IO1: if (args_left == 2'd1) io_base1_out[g*16 +: 16] <= {hi_byte, addr_data_in};
            F_IO2: if (args_left == 2'd1) io_base2_out[g*16 +: 16] <= {hi_byte, addr_data_in};
            F_IRQ0: irq_sel0_out[g*8 +: 8] <= addr_data_in;
            F_IRQ1: irq_sel1_out[g*8 +: 8] <= addr_data_in;
            F_DMA0: dma_sel0_out[g*8 +: 8] <= addr_data_in;
            F_DMA1: dma_sel1_out[g*8 +: 8] <= addr_data_in;
            F_ACT: begin
              if (addr_data_in == ACT_ON) begin
                ldev_active_out[g] <= 1'b1;
              end else if (addr_data_in == ACT_OFF) begin
                ldev_active_out[g] <= 1'b0;
              end
            end
            default: begin
            end
          endcase
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_last_key;
    addr_wr_in && addr_data_in == VKEY_LAST && key_idx == 5'(KEY_LEN - 1) && !vend_key_off;
  endsequence
  property p_key_enter;
    @(posedge core_clk_in) disable iff (reset_in) s_last_key |=> config_mode_out;
  endproperty
  a_key_enter: assert property (p_key_enter) else $error("key did not enter config mode");

  property p_key_mismatch;
    @(posedge core_clk_in) disable iff (reset_in)
      addr_wr_in && !key_hit && addr_data_in != VKEY_FIRST |=> key_idx == 5'h00;
  endproperty
  a_key_mismatch: assert property (p_key_mismatch) else $error("key index not restarted");

  property p_key_step;
    @(posedge core_clk_in) disable iff (reset_in)
      addr_wr_in && key_hit && !vend_key_off |=> key_idx == $past(key_idx) + 5'h01;
  endproperty
  a_key_step: assert property (p_key_step) else $error("key index did not advance");

  sequence s_csn_load;
    cmd_wr && addr_data_in == CMD_CSN ##1 addr_wr_in;
  endsequence
  property p_csn;
    @(posedge core_clk_in) disable iff (reset_in) s_csn_load |=> csn_out == $past(addr_data_in);
  endproperty
  a_csn: assert property (p_csn) else $error("csn not stored");

  sequence s_io0_load;
    cmd_wr && addr_data_in == CMD_IO0 && ldev_sel_out == 3'h0 ##1 addr_wr_in ##1 addr_wr_in;
  endsequence
  property p_io_base;
    @(posedge core_clk_in) disable iff (reset_in)
      s_io0_load |=> io_base0_out[15:0] == {$past(addr_data_in, 2), $past(addr_data_in)};
  endproperty
  a_io_base: assert property (p_io_base) else $error("io base wrong");

  property p_chip_on;
    @(posedge core_clk_in) disable iff (reset_in) cmd_wr && addr_data_in == CMD_CHIP_ON |=> chip_active_out;
  endproperty
  a_chip_on: assert property (p_chip_on) else $error("chip not activated");

  property p_std_sticky;
    @(posedge core_clk_in) disable iff (reset_in) std_key_disabled_out |=> std_key_disabled_out;
  endproperty
  a_std_sticky: assert property (p_std_sticky) else $error("standard key re-enabled");

  property p_vend_dis;
    @(posedge core_clk_in) disable iff (reset_in)
      ctrl_wr_in && ctrl_offset_in == KEY_DIS_OFFSET && ctrl_data_in == DIS_VEND_KEY |=> vend_key_disabled_out;
  endproperty
  a_vend_dis: assert property (p_vend_dis) else $error("vendor key not disabled");

  property p_args;
    @(posedge core_clk_in) disable iff (reset_in)
      cmd_wr && addr_data_in == CMD_IO1 |=> args_left == 2'd2;
  endproperty
  a_args: assert property (p_args) else $error("argument count wrong");

  property p_ldev_sel;
    @(posedge core_clk_in) disable iff (reset_in)
      arg_wr && pend_field == F_LDEV && addr_data_in <= {5'h00, LDEV_MAX}
      |=> ldev_sel_out == $past(addr_data_in[2:0]);
  endproperty
  a_ldev_sel: assert property (p_ldev_sel) else $error("logical device not selected");

  sequence s_irq0_load;
    cmd_wr && addr_data_in == CMD_IRQ0 && ldev_sel_out == 3'h0 ##1 addr_wr_in;
  endsequence
  property p_irq0;
    @(posedge core_clk_in) disable iff (reset_in) s_irq0_load |=> irq_sel0_out[7:0] == $past(addr_data_in);
  endproperty
  a_irq0: assert property (p_irq0) else $error("irq select wrong");

  sequence s_act_cmd;
    cmd_wr && addr_data_in == CMD_ACT ##1 addr_wr_in;
  endsequence
  property p_act_on;
    @(posedge core_clk_in) disable iff (reset_in)
      s_act_cmd ##0 addr_data_in == ACT_ON |=> ldev_active_out[ldev_sel_out];
  endproperty
  a_act_on: assert property (p_act_on) else $error("device not activated");

  property p_act_off;
    @(posedge core_clk_in) disable iff (reset_in)
      s_act_cmd ##0 addr_data_in == ACT_OFF |=> !ldev_active_out[ldev_sel_out];
  endproperty
  a_act_off: assert property (p_act_off) else $error("device not deactivated");

  property p_idle;
    @(posedge core_clk_in) disable iff (reset_in)
      !config_mode_out |=> !chip_active_out && $stable(csn_out) && $stable(ldev_active_out);
  endproperty
  a_idle: assert property (p_idle) else $error("programming outside config mode");

  property p_hostload_clr;
    @(posedge core_clk_in) disable iff (reset_in) hostload_done_in && !key_done |=> !hostload_enable_out;
  endproperty
  a_hostload_clr: assert property (p_hostload_clr) else $error("hostload enable not cleared");

  property p_std_dis;
    @(posedge core_clk_in) disable iff (reset_in)
      ctrl_wr_in && ctrl_offset_in == KEY_DIS_OFFSET && ctrl_data_in == DIS_STD_KEY |=> std_key_disabled_out;
  endproperty
  a_std_dis: assert property (p_std_dis) else $error("standard key not disabled");

endmodule
`default_nettype wire

// >>> isa_host.sv
`default_nettype none
module isa_host (
  input wire logic clk_in,
  output logic addr_wr_out,
  output logic [7:0] addr_data_out,
  output logic ctrl_wr_out,
  output logic [2:0] ctrl_offset_out,
  output logic [7:0] ctrl_data_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // vendor key table
  // ----------------------------------------
  localparam logic [7:0] KEY [32] = '{
    8'h96, 8'h35, 8'h9A, 8'hCD, 8'hE6, 8'hF3, 8'h79, 8'hBC, 8'h5E, 8'hAF, 8'h57, 8'h2B, 8'h15, 8'h8A, 8'hC5, 8'hE2,
    8'hF1, 8'hF8, 8'h7C, 8'h3E, 8'h9F, 8'h4F, 8'h27, 8'h13, 8'h09, 8'h84, 8'h42, 8'hA1, 8'hD0, 8'h68, 8'h34, 8'h1A};
  initial begin
    addr_wr_out = 1'b0;
    addr_data_out = 8'hA5;
    ctrl_wr_out = 1'b0;
    ctrl_offset_out = 3'h0;
    ctrl_data_out = 8'h5A;
  end
  // ----------------------------------------
  // host write cycles
  // ----------------------------------------
  // address port write, strobe kept high for back to back
  task automatic wr(input logic [7:0] d);
    ctrl_wr_out = 1'b0;
    addr_wr_out = 1'b1;
    addr_data_out = d;
    @(posedge clk_in) #1;
  endtask
  task automatic cw(input logic [2:0] o, input logic [7:0] d);
    addr_wr_out = 1'b0;
    ctrl_wr_out = 1'b1;
    ctrl_offset_out = o;
    ctrl_data_out = d;
    @(posedge clk_in) #1;
  endtask
  // released lines show inverse of last value
  task automatic idle(input int n);
    addr_wr_out = 1'b0;
    ctrl_wr_out = 1'b0;
    addr_data_out = ~addr_data_out;
    ctrl_data_out = ~ctrl_data_out;
    repeat (n) @(posedge clk_in) #1;
  endtask
  // full key in order, optional bad byte, optional gaps
  task automatic key(input int bad, input logic slow);
    for (int i = 0; i < 32; i++) begin
      if (i == bad) wr(8'h00);
      wr(KEY[i]);
      if (slow) idle(1);
    end
    idle(1);
  endtask
endmodule
`default_nettype wire

// >>> config_key_and_direct_program_tb.sv
`default_nettype none
module config_key_and_direct_program_tb
  import cfg_key_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] IO_CMD [3] = '{CMD_IO0, CMD_IO1, CMD_IO2};
  localparam logic [7:0] SEL_CMD [4] = '{CMD_IRQ0, CMD_IRQ1, CMD_DMA0, CMD_DMA1};
  logic core_clk_in, reset_in, addr_wr_in, ctrl_wr_in, hostload_done_in;
  logic eeprom_std_key_dis_in, eeprom_vend_key_dis_in;
  logic [7:0] addr_data_in, ctrl_data_in, csn_out, hi, lo;
  logic [2:0] ctrl_offset_in, ldev_sel_out;
  logic config_mode_out, chip_active_out, std_key_disabled_out, vend_key_disabled_out, hostload_enable_out;
  logic [NUM_LDEV-1:0] ldev_active_out;
  logic [NUM_LDEV*16-1:0] io_base0_out, io_base1_out, io_base2_out;
  logic [NUM_LDEV*8-1:0] irq_sel0_out, irq_sel1_out, dma_sel0_out, dma_sel1_out;
  logic [95:0] e_io [3] = '{default: '0};
  logic [47:0] e_sel [4] = '{default: '0};
  logic [5:0] e_act = '0;
  logic [31:0] seed = 32'h0000870F;
  int bad_count = 0;
  int compares = 0;
  config_key_and_direct_program config_key_and_direct_program_inst (
    .core_clk_in, .reset_in, .addr_wr_in, .addr_data_in, .ctrl_wr_in, .ctrl_offset_in, .ctrl_data_in,
    .eeprom_std_key_dis_in, .eeprom_vend_key_dis_in, .hostload_done_in, .config_mode_out, .chip_active_out,
    .std_key_disabled_out, .vend_key_disabled_out, .hostload_enable_out, .csn_out, .ldev_sel_out,
    .ldev_active_out, .io_base0_out, .io_base1_out, .io_base2_out, .irq_sel0_out, .irq_sel1_out,
    .dma_sel0_out, .dma_sel1_out);
  isa_host isa_host_inst (.clk_in(core_clk_in), .addr_wr_out(addr_wr_in), .addr_data_out(addr_data_in),
    .ctrl_wr_out(ctrl_wr_in), .ctrl_offset_out(ctrl_offset_in), .ctrl_data_out(ctrl_data_in));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  function automatic logic [4:0] fl();
    return {config_mode_out, chip_active_out, std_key_disabled_out, vend_key_disabled_out, hostload_enable_out};
  endfunction
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic t_end(input string s);
    $display("%0t test %s done", $time, s);
  endtask
  task automatic do_rst();
    reset_in = 1'b1;
    repeat (8) @(posedge core_clk_in);
    #1 reset_in = 1'b0;
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // clock and watchdog
  // ----------------------------------------
  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  initial begin
    repeat (100000) @(posedge core_clk_in);
    $display("[ERR] %0t run too long", $time);
    bad_count++;
    finish_test();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    hostload_done_in = 1'b0;
    eeprom_std_key_dis_in = 1'b0;
    eeprom_vend_key_dis_in = 1'b0;
    do_rst();
    chk(96'(fl()), 96'(5'h00));
    isa_host_inst.key(10, 1'b0);
    chk(96'(fl()), 96'(5'h00));
    isa_host_inst.key(32, 1'b1);
    chk(96'(fl()), 96'(5'h11));
    hostload_done_in = 1'b1;
    @(posedge core_clk_in) #1;
    hostload_done_in = 1'b0;
    isa_host_inst.idle(1);
    chk(96'(fl()), 96'(5'h10));
    t_end("key");
    hi = rnd();
    isa_host_inst.wr(CMD_CSN);
    isa_host_inst.wr(hi);
    for (int d = 0; d < 6; d++) begin
      isa_host_inst.wr(CMD_LDEV);
      isa_host_inst.wr(8'(d));
      for (int k = 0; k < 3; k++) begin
        lo = (d == 0) ? CMD_CHIP_ON : rnd();
        isa_host_inst.wr(IO_CMD[k]);
        isa_host_inst.wr(lo);
        isa_host_inst.wr(8'(k + d));
        e_io[k][16*d+:16] = {lo, 8'(k + d)};
      end
      for (int k = 0; k < 4; k++) begin
        lo = rnd();
        isa_host_inst.wr(SEL_CMD[k]);
        isa_host_inst.wr(lo);
        e_sel[k][8*d+:8] = lo;
      end
      isa_host_inst.wr(CMD_ACT);
      isa_host_inst.wr(ACT_ON);
      e_act[d] = ~d[0];
      if (d[0]) isa_host_inst.wr(CMD_ACT);
      if (d[0]) isa_host_inst.wr(ACT_OFF);
    end
    isa_host_inst.wr(CMD_LDEV);
    isa_host_inst.wr(8'h04);
    isa_host_inst.wr(CMD_ACT);
    isa_host_inst.wr(8'h02);
    isa_host_inst.wr(CMD_LDEV);
    isa_host_inst.wr(8'h07);
    isa_host_inst.idle(1);
    chk(96'(csn_out), 96'(hi));
    chk(96'(ldev_sel_out), 96'(3'h4));
    chk(io_base0_out, e_io[0]);
    chk(io_base1_out, e_io[1]);
    chk(io_base2_out, e_io[2]);
    chk(96'(irq_sel0_out), 96'(e_sel[0]));
    chk(96'(irq_sel1_out), 96'(e_sel[1]));
    chk(96'(dma_sel0_out), 96'(e_sel[2]));
    chk(96'(dma_sel1_out), 96'(e_sel[3]));
    chk(96'(ldev_active_out), 96'(e_act));
    chk(96'(fl()), 96'(5'h10));
    t_end("program");
    isa_host_inst.wr(CMD_CHIP_ON);
    isa_host_inst.idle(1);
    chk(96'(fl()), 96'(5'h18));
    for (int i = 0; i < 16; i++) begin
      lo = rnd();
      isa_host_inst.cw(lo[2:0], rnd() | 8'h80);
    end
    isa_host_inst.idle(1);
    chk(96'(fl()), 96'(5'h18));
    isa_host_inst.cw(3'h4, DIS_VEND_KEY);
    isa_host_inst.cw(KEY_DIS_OFFSET, DIS_STD_KEY);
    isa_host_inst.idle(1);
    chk(96'(fl()), 96'(5'h1C));
    isa_host_inst.cw(KEY_DIS_OFFSET, DIS_VEND_KEY);
    isa_host_inst.idle(1);
    chk(96'(fl()), 96'(5'h1E));
    chk(96'(ldev_active_out), 96'(e_act));
    t_end("disable");
    do_rst();
    chk(96'({fl(), csn_out}), 96'(13'h0000));
    isa_host_inst.key(32, 1'b0);
    chk(96'(fl()), 96'(5'h11));
    lo = rnd();
    for (int i = 0; i < 8; i++) begin
      hostload_done_in = lo[i];
      @(posedge core_clk_in) #1;
    end
    hostload_done_in = 1'b0;
    chk(96'(fl()), 96'({4'h8, lo == 8'h00}));
    do_rst();
    lo = rnd();
    eeprom_std_key_dis_in = lo[0];
    eeprom_vend_key_dis_in = lo[1];
    isa_host_inst.cw(KEY_DIS_OFFSET, DIS_VEND_KEY);
    eeprom_std_key_dis_in = 1'b0;
    eeprom_vend_key_dis_in = 1'b0;
    isa_host_inst.key(32, 1'b0);
    chk(96'(fl()), 96'({2'h0, lo[0], 2'h2}));
    do_rst();
    eeprom_std_key_dis_in = 1'b1;
    eeprom_vend_key_dis_in = 1'b1;
    isa_host_inst.idle(2);
    eeprom_std_key_dis_in = 1'b0;
    eeprom_vend_key_dis_in = 1'b0;
    isa_host_inst.key(32, 1'b0);
    chk(96'(fl()), 96'(5'h06));
    t_end("reset");
    finish_test();
  end
endmodule
`default_nettype wire
